// ==== pkg/rss_cfg.svh ====
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// ==========================================================
// Timing
`define RSS_CLK_PERIOD_NS    10
`define RSS_POR_DELAY_NS     300000
`define RSS_POR_CYC          (`RSS_POR_DELAY_NS / `RSS_CLK_PERIOD_NS)
`define RSS_VMON_CYC         1
`define RSS_SOFT_HOLD_CYC    8'h0_8

// ==========================================================
// Register addresses
`define RSS_ADDR_CAUSE       8'hE_F
`define RSS_ADDR_VMON        8'h3_0
`define RSS_ADDR_IRQ_STAT    8'h3_1
`define RSS_ADDR_IRQ_MASK    8'h3_2

// ==========================================================
// Field positions
`define RSS_BIT_PIN          0
`define RSS_BIT_POR          1
`define RSS_BIT_SOFT         4
`define RSS_BIT_VMON_EN      0
`define RSS_IRQ_VFAIL        0
`define RSS_IRQ_PIN          1
`define RSS_IRQ_FLASH_REF    2

// ==========================================================
// Reset values
`define RSS_CAUSE_POR_VAL    8'h0_2
`define RSS_CAUSE_PIN_VAL    8'h0_1
`define RSS_CAUSE_WDT_VAL    8'h0_8
`define RSS_CAUSE_SOFT_VAL   8'h1_0
`define RSS_CAUSE_FERR_VAL   8'h4_0
`define RSS_PORT_LATCH_RST   8'hF_F
`define RSS_FETCH_ADDR_RST   16'h0_000
`define RSS_ZERO8            8'h0_0

`endif

// ==== pkg/rss_pkg.sv ====
package rss_pkg;

	// ==========================================================
	// Sequencer states
	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_RUN  = 2'b01
	} rss_state_t;

	// ==========================================================
	// Reset cause register layout
	typedef struct packed {
		logic rsvd;
		logic ferr;
		logic cmp;
		logic soft_reset_force_flag;
		logic wdt;
		logic mcd;
		logic power_on_cause_flag;
		logic pin_reset_cause_flag;
	} rss_cause_t;

	// ==========================================================
	// Port pad defaults driven to the port block
	typedef struct packed {
		logic [7:0] latch;
		logic       push_pull;
		logic       high_drive;
		logic       weak_pullup;
	} rss_port_t;

endpackage

// ==== hdl/rss_rel_sync.sv ====
`timescale 1ns/1ps
`include "rss_cfg.svh"

// Asynchronous assert, synchronous release with a counted delay
module rss_rel_sync #(
	parameter int CNT_W = 16,
	parameter int DELAY = 1
) (
	// Clock and reset source
	input  wire logic i_core_clk,
	input  wire logic i_arst_n,
	// Release
	output logic      o_rel
);

	logic             sync1_ff;
	logic             sync2_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic             rel_ff;
	logic             nxt_rel;

	// Count cycles once the release edge is through the synchroniser
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_rel = rel_ff;
		if (sync2_ff && !rel_ff) begin
			if (cnt_ff >= CNT_W'(DELAY - 1)) begin
				nxt_rel = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + CNT_W'(1);
			end
		end
	end

	// Registers
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			cnt_ff   <= '0;
			rel_ff   <= 1'b0;
		end else begin
			sync1_ff <= 1'b1;
			sync2_ff <= sync1_ff;
			cnt_ff   <= nxt_cnt;
			rel_ff   <= nxt_rel;
		end
	end

	assign o_rel = rel_ff;

endmodule

// ==== hdl/rss_reset_seq.sv ====
`timescale 1ns/1ps
`include "rss_cfg.svh"

module rss_reset_seq
	import rss_pkg::*;
#(
	parameter int POR_CYC = `RSS_POR_CYC,
	parameter int CNT_W   = 16
) (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// Supply sensing
	input  wire logic        i_por_n,
	input  wire logic        i_vdd_ok,
	// External reset pin
	input  wire logic        i_rst_pin_in,
	output logic             o_rst_pin_out,
	output logic             o_rst_pin_oe,
	// Other reset sources
	input  wire logic        i_wdt_timeout,
	input  wire logic        i_flash_err,
	// Register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	// Core and peripherals
	output logic             o_core_rst_n,
	output logic             o_sfr_rst_n,
	output logic             o_sp_rst_n,
	output logic             o_irq_tmr_dis,
	output logic             o_start,
	output logic      [15:0] o_fetch_addr,
	output logic             o_clk_sel_int,
	output logic             o_wdt_en,
	input  wire logic [7:0]  i_port_latch_sw,
	input  wire logic        i_port_pp_sw,
	input  wire logic        i_port_hd_sw,
	output rss_port_t        o_port,
	// Flash gating
	input  wire logic        i_flash_wr_req,
	input  wire logic        i_flash_er_req,
	output logic             o_flash_wr_go,
	output logic             o_flash_er_go,
	// Interrupt
	output logic             o_irq
);

	// ==========================================================
	// Reset trees
	logic por_arst_n;
	logic por_rel;
	logic vmon_arst_n;
	logic vmon_rel;
	logic vmon_en_ff;
	logic vmon_sel_ff;
	logic nxt_vmon_en;
	logic nxt_vmon_sel;

	// Power-on detector and reset input assert asynchronously
	assign por_arst_n = i_rst_n & i_por_n;

	// Power-on release waits for the threshold, then counts
	rss_rel_sync #(
		.CNT_W (CNT_W),
		.DELAY (POR_CYC)
	) u_por_rel (
		.i_core_clk (i_core_clk),
		.i_arst_n   (por_arst_n & (i_vdd_ok | por_rel)),
		.o_rel      (por_rel)
	);

	// Monitor drop asserts asynchronously while enabled and selected
	assign vmon_arst_n = por_arst_n &
		(i_vdd_ok | ~(vmon_en_ff & vmon_sel_ff));

	// Monitor release uses the short path, no power-on delay
	rss_rel_sync #(
		.CNT_W (CNT_W),
		.DELAY (`RSS_VMON_CYC)
	) u_vmon_rel (
		.i_core_clk (i_core_clk),
		.i_arst_n   (vmon_arst_n),
		.o_rel      (vmon_rel)
	);

	// ==========================================================
	// Sequencer state
	rss_state_t state_ff;
	rss_state_t nxt_state;
	logic [7:0] hold_ff;
	logic [7:0] nxt_hold;
	rss_cause_t cause_ff;
	rss_cause_t nxt_cause;
	logic       start_ff;
	logic       nxt_start;
	logic [7:0] stat_ff;
	logic [7:0] nxt_stat;
	logic [7:0] mask_ff;
	logic [7:0] nxt_mask;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic       irq_ff;
	logic       nxt_irq;
	rss_port_t  port_ff;
	rss_port_t  nxt_port;
	logic       in_reset;
	logic       pin_low;
	logic       soft_wr;
	logic       wr_cause;
	logic       wr_vmon;
	logic       flash_ref;
	logic [7:0] set_ev;

	// Pin low driven by someone else, not our own pull-down
	assign pin_low  = ~i_rst_pin_in & ~o_rst_pin_oe;
	assign wr_cause = i_wr && (i_addr == `RSS_ADDR_CAUSE);
	assign wr_vmon  = i_wr && (i_addr == `RSS_ADDR_VMON);
	assign soft_wr  = wr_cause && i_wdata[`RSS_BIT_SOFT];
	assign in_reset = ~por_rel | ~vmon_rel | (state_ff != ST_RUN);

	// Flash requests refused while the monitor is off
	assign flash_ref = (i_flash_wr_req | i_flash_er_req) & ~vmon_en_ff;

	// Sequencer next state and cause capture
	always_comb begin
		nxt_state = state_ff;
		nxt_hold  = hold_ff;
		nxt_cause = cause_ff;
		nxt_start = 1'b0;
		if (!por_rel) begin
			nxt_state = ST_HOLD;
			nxt_cause = rss_cause_t'(`RSS_CAUSE_POR_VAL);
		end else if (!vmon_rel) begin
			nxt_state = ST_HOLD;
			nxt_hold  = `RSS_ZERO8;
			nxt_cause = rss_cause_t'(`RSS_CAUSE_POR_VAL);
		end else begin
			case (state_ff)
				ST_HOLD: begin
					if (pin_low) begin
						nxt_hold = `RSS_ZERO8;
					end else if (hold_ff != `RSS_ZERO8) begin
						nxt_hold = hold_ff - 8'h0_1;
					end else begin
						nxt_state = ST_RUN;
						nxt_start = 1'b1;
					end
				end
				ST_RUN: begin
					if (pin_low) begin
						nxt_state = ST_HOLD;
						nxt_cause = rss_cause_t'(`RSS_CAUSE_PIN_VAL);
					end else if (soft_wr) begin
						nxt_state = ST_HOLD;
						nxt_hold  = `RSS_SOFT_HOLD_CYC;
						nxt_cause = rss_cause_t'(`RSS_CAUSE_SOFT_VAL);
					end else if (i_wdt_timeout) begin
						nxt_state = ST_HOLD;
						nxt_hold  = `RSS_SOFT_HOLD_CYC;
						nxt_cause = rss_cause_t'(`RSS_CAUSE_WDT_VAL);
					end else if (i_flash_err) begin
						nxt_state = ST_HOLD;
						nxt_hold  = `RSS_SOFT_HOLD_CYC;
						nxt_cause = rss_cause_t'(`RSS_CAUSE_FERR_VAL);
					end
				end
				default: begin
					nxt_state = ST_HOLD;
				end
			endcase
		end
	end

	// Sequencer registers live in the power-on domain
	always_ff @(posedge i_core_clk or negedge por_arst_n) begin
		if (!por_arst_n) begin
			state_ff <= ST_HOLD;
			hold_ff  <= `RSS_ZERO8;
			cause_ff <= rss_cause_t'(`RSS_CAUSE_POR_VAL);
			start_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			hold_ff  <= nxt_hold;
			cause_ff <= nxt_cause;
			start_ff <= nxt_start;
		end
	end

	// ==========================================================
	// Supply monitor control
	always_comb begin
		nxt_vmon_en  = vmon_en_ff;
		nxt_vmon_sel = vmon_sel_ff;
		if (wr_vmon) begin
			nxt_vmon_en = i_wdata[`RSS_BIT_VMON_EN];
		end
		if (wr_cause) begin
			nxt_vmon_sel = i_wdata[`RSS_BIT_POR];
		end
	end

	// Only power-on resets these, so other resets keep them
	always_ff @(posedge i_core_clk or negedge por_arst_n) begin
		if (!por_arst_n) begin
			vmon_en_ff  <= 1'b1;
			vmon_sel_ff <= 1'b1;
		end else begin
			vmon_en_ff  <= nxt_vmon_en;
			vmon_sel_ff <= nxt_vmon_sel;
		end
	end

	// ==========================================================
	// Interrupt status, mask and read port
	// Monitor event only once power-on has let go, so power-up is not one
	assign set_ev = {5'b0_0000, flash_ref,
		(state_ff == ST_RUN) & pin_low, por_rel & ~vmon_rel};

	// Set beats clear-on-read; mask write
	always_comb begin
		nxt_stat  = stat_ff;
		nxt_mask  = mask_ff;
		nxt_rdata = `RSS_ZERO8;
		if (i_rd) begin
			case (i_addr)
				`RSS_ADDR_CAUSE:    nxt_rdata = cause_ff;
				`RSS_ADDR_VMON:     nxt_rdata = {7'b000_0000, vmon_en_ff};
				`RSS_ADDR_IRQ_STAT: begin
					nxt_rdata = stat_ff;
					nxt_stat  = `RSS_ZERO8;
				end
				`RSS_ADDR_IRQ_MASK: nxt_rdata = mask_ff;
				default:            nxt_rdata = `RSS_ZERO8;
			endcase
		end
		if (i_wr && (i_addr == `RSS_ADDR_IRQ_MASK)) begin
			nxt_mask = i_wdata;
		end
		nxt_stat = nxt_stat | set_ev;
		nxt_irq  = |(stat_ff & mask_ff);
	end

	// Status survives system resets so the event can be read
	always_ff @(posedge i_core_clk or negedge por_arst_n) begin
		if (!por_arst_n) begin
			stat_ff  <= `RSS_ZERO8;
			mask_ff  <= `RSS_ZERO8;
			rdata_ff <= `RSS_ZERO8;
			irq_ff   <= 1'b0;
		end else begin
			stat_ff  <= nxt_stat;
			mask_ff  <= nxt_mask;
			rdata_ff <= nxt_rdata;
			irq_ff   <= nxt_irq;
		end
	end

	// ==========================================================
	// Port pad defaults
	always_comb begin
		if (in_reset) begin
			nxt_port.latch       = `RSS_PORT_LATCH_RST;
			nxt_port.push_pull   = 1'b0;
			nxt_port.high_drive  = 1'b0;
		end else begin
			nxt_port.latch       = i_port_latch_sw;
			nxt_port.push_pull   = i_port_pp_sw;
			nxt_port.high_drive  = i_port_hd_sw;
		end
		nxt_port.weak_pullup = 1'b1;
	end

	// Pad registers
	always_ff @(posedge i_core_clk or negedge por_arst_n) begin
		if (!por_arst_n) begin
			port_ff <= {`RSS_PORT_LATCH_RST, 3'b001};
		end else begin
			port_ff <= nxt_port;
		end
	end

	// ==========================================================
	// Outputs
	// Core, registers and stack pointer held; data memory untouched
	assign o_core_rst_n  = ~in_reset;
	assign o_sfr_rst_n   = ~in_reset;
	assign o_sp_rst_n    = ~in_reset;
	assign o_irq_tmr_dis = in_reset;
	// Pin pulled low only for power-on and monitor resets
	assign o_rst_pin_out = 1'b0;
	assign o_rst_pin_oe  = ~por_rel | ~vmon_rel;
	// Exit pulse restarts at the vector on the internal clock
	assign o_start       = start_ff;
	assign o_wdt_en      = start_ff;
	assign o_clk_sel_int = start_ff;
	assign o_fetch_addr  = `RSS_FETCH_ADDR_RST;
	assign o_port        = port_ff;
	// Flash operations pass only with the monitor enabled
	assign o_flash_wr_go = i_flash_wr_req & vmon_en_ff;
	assign o_flash_er_go = i_flash_er_req & vmon_en_ff;
	assign o_rdata       = rdata_ff;
	assign o_irq         = irq_ff;

endmodule

// ==== dv/rss_pin_model.sv ====
`timescale 1ns/1ps
// ==========
// Reset pin wire: pull-up, device pull-down, external pusher
module rss_pin_model (
	// Drivers
	input  wire logic i_oe,
	input  wire logic i_out,
	input  wire logic i_ext_low,
	// Resolved level
	output logic      o_pin
);
	// Pull-up wins unless a party pulls the wire low
	assign o_pin = (i_oe ? i_out : 1'b1) & ~i_ext_low;
endmodule

// ==== dv/rss_reset_seq_assertions.sv ====
`timescale 1ns/1ps
// ==========
// Port-level checker for the reset sequencer
module rss_reset_seq_checker
	import rss_pkg::*;
(
	// Clock, reset, supply
	input wire logic        i_core_clk,
	input wire logic        i_rst_n,
	input wire logic        i_por_n,
	input wire logic        i_vdd_ok,
	// Core side
	input wire logic        o_rst_pin_oe,
	input wire logic        o_core_rst_n,
	input wire logic        o_sfr_rst_n,
	input wire logic        o_sp_rst_n,
	input wire logic        o_irq_tmr_dis,
	input wire logic        o_start,
	input wire logic [15:0] o_fetch_addr,
	input wire logic        o_clk_sel_int,
	input wire logic        o_wdt_en,
	input wire rss_port_t   o_port,
	input wire logic        i_flash_wr_req,
	input wire logic        o_flash_wr_go
);
	logic ran_ff;
	logic nxt_ran;
	// Set once the core has run since power-on
	always_comb nxt_ran = ran_ff | o_core_rst_n;
	always_ff @(posedge i_core_clk or negedge i_rst_n or negedge i_por_n) begin
		if (!i_rst_n || !i_por_n) ran_ff <= 1'b0;
		else ran_ff <= nxt_ran;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// ==========
	// Assertions
	a_por_hold: assert property (!i_por_n |->
		!o_core_rst_n && o_rst_pin_oe)
		else $error("core free while power-on detector low");
	a_core_halt: assert property (!o_core_rst_n |->
		!o_sfr_rst_n && !o_sp_rst_n && o_irq_tmr_dis)
		else $error("reset outputs disagree");
	a_port_safe: assert property (!o_core_rst_n [*2] |->
		o_port == {8'hFF, 1'b0, 1'b0, 1'b1})
		else $error("pads not in safe state");
	a_pin_driven: assert property (o_rst_pin_oe |-> !o_core_rst_n)
		else $error("pin driven low while core runs");
	a_exit_start: assert property ($rose(o_core_rst_n) |->
		o_start && o_wdt_en && o_clk_sel_int)
		else $error("exit without start pulses");
	a_start_pulse: assert property (o_start |=>
		!o_start && o_core_rst_n)
		else $error("start pulse malformed");
	a_fetch_zero: assert property (o_start |->
		o_fetch_addr == 16'h0000)
		else $error("fetch address not zero");
	a_oe_release: assert property ($fell(o_rst_pin_oe) |=>
		o_core_rst_n)
		else $error("core still held after pin release");
	a_vmon_fast: assert property (ran_ff && $rose(i_vdd_ok) |->
		##[1:6] !o_rst_pin_oe)
		else $error("monitor release too slow");
	a_flash_req: assert property (o_flash_wr_go |-> i_flash_wr_req)
		else $error("flash write without request");
	// Main scenarios
	c_exit: cover property ($rose(o_core_rst_n));
	c_vmon: cover property ($fell(i_vdd_ok) ##[1:4] o_rst_pin_oe);
	c_refuse: cover property (i_flash_wr_req && !o_flash_wr_go);
endmodule

bind rss_reset_seq rss_reset_seq_checker u_chk (.i_core_clk, .i_rst_n,
	.i_por_n, .i_vdd_ok, .o_rst_pin_oe, .o_core_rst_n, .o_sfr_rst_n,
	.o_sp_rst_n, .o_irq_tmr_dis, .o_start, .o_fetch_addr, .o_clk_sel_int,
	.o_wdt_en, .o_port, .i_flash_wr_req, .o_flash_wr_go);

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`include "rss_cfg.svh"
module tb_top import rss_pkg::*;;
	logic        i_core_clk     = 1'b0;
	logic        i_rst_n        = 1'b0;
	logic        i_por_n        = 1'b0;
	logic        i_vdd_ok       = 1'b1;
	logic        ext_low        = 1'b0;
	logic        i_wdt_timeout  = 1'b0;
	logic        i_flash_err    = 1'b0;
	logic [7:0]  i_addr         = 8'h00;
	logic [7:0]  i_wdata        = 8'h00;
	logic        i_wr           = 1'b0;
	logic        i_rd           = 1'b0;
	logic [7:0]  i_port_latch_sw = 8'hA5;
	logic        i_port_pp_sw   = 1'b1;
	logic        i_port_hd_sw   = 1'b1;
	logic        i_flash_wr_req = 1'b0;
	logic        i_flash_er_req = 1'b0;
	logic        rst_pin;
	logic        o_rst_pin_out, o_rst_pin_oe, o_core_rst_n, o_sfr_rst_n;
	logic        o_sp_rst_n, o_irq_tmr_dis, o_start, o_clk_sel_int, o_wdt_en;
	logic        o_flash_wr_go, o_flash_er_go, o_irq;
	logic [7:0]  o_rdata;
	logic [15:0] o_fetch_addr;
	rss_port_t   o_port;
	logic [7:0]  rd_val;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          n_wait;
	int          i;

	// Design with a short power-on delay
	rss_reset_seq #(.POR_CYC(8)) dut (.i_core_clk, .i_rst_n, .i_por_n,
		.i_vdd_ok, .i_rst_pin_in(rst_pin), .o_rst_pin_out, .o_rst_pin_oe,
		.i_wdt_timeout, .i_flash_err, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .o_core_rst_n, .o_sfr_rst_n, .o_sp_rst_n, .o_irq_tmr_dis,
		.o_start, .o_fetch_addr, .o_clk_sel_int, .o_wdt_en, .i_port_latch_sw,
		.i_port_pp_sw, .i_port_hd_sw, .o_port, .i_flash_wr_req,
		.i_flash_er_req, .o_flash_wr_go, .o_flash_er_go, .o_irq);
	rss_pin_model u_pin (.i_oe(o_rst_pin_oe), .i_out(o_rst_pin_out),
		.i_ext_low(ext_low), .o_pin(rst_pin));

	// Clock at 100 MHz
	initial begin
		forever #5 i_core_clk = ~i_core_clk;
	end

	// ==========
	// Helpers
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		rd_val = o_rdata;
	endtask
	task wait_start;
		n_wait = 0;
		do begin
			@(posedge i_core_clk);
			#1;
			n_wait++;
		end while (o_start !== 1'b1 && n_wait < 100);
		chk(o_start, 1'b1);
	endtask

	// ==========
	// Scenarios
	task t_power_on;
		chk(o_rst_pin_oe, 1'b1);
		chk(o_port, {8'hFF, 3'b001});
		@(posedge i_core_clk);
		i_por_n <= 1'b1;
		wait_start;
		chk(n_wait >= 10, 1'b1);
		chk({o_wdt_en, o_clk_sel_int, o_fetch_addr}, 18'h30000);
		rd(`RSS_ADDR_CAUSE);
		chk(rd_val, 8'h02);
		rd(`RSS_ADDR_VMON);
		chk({rd_val, o_port.weak_pullup, o_port.latch}, 17'h0_03A5);
		rd(8'h55);
		chk(rd_val, 8'h00);
		$display("power-on test done");
	endtask
	task t_soft;
		// Keep bit 1 set so the monitor stays selected as a reset source
		wr(`RSS_ADDR_CAUSE, 8'h12);
		#1;
		chk({o_core_rst_n, o_rst_pin_oe}, 2'b00);
		wait_start;
		rd(`RSS_ADDR_CAUSE);
		chk(rd_val, 8'h10);
		$display("soft reset test done");
	endtask
	task t_wdt_ferr;
		for (i = 0; i < 2; i++) begin
			@(posedge i_core_clk);
			i_wdt_timeout <= (i == 0);
			i_flash_err <= (i == 1);
			@(posedge i_core_clk);
			i_wdt_timeout <= 1'b0;
			i_flash_err <= 1'b0;
			wait_start;
			rd(`RSS_ADDR_CAUSE);
			chk(rd_val, (i == 0) ? 8'h08 : 8'h40);
		end
		$display("watchdog and flash error test done");
	endtask
	task t_pin;
		wr(`RSS_ADDR_IRQ_MASK, 8'h02);
		@(posedge i_core_clk);
		ext_low <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		#1;
		chk({o_core_rst_n, o_rst_pin_oe}, 2'b00);
		@(posedge i_core_clk);
		ext_low <= 1'b0;
		wait_start;
		rd(`RSS_ADDR_CAUSE);
		chk({rd_val, o_irq}, 9'h003);
		rd(`RSS_ADDR_IRQ_STAT);
		chk(rd_val, 8'h02);
		repeat (2) @(posedge i_core_clk);
		#1;
		chk(o_irq, 1'b0);
		$display("pin reset test done");
	endtask
	task t_vmon;
		@(posedge i_core_clk);
		i_vdd_ok <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		#1;
		chk({o_core_rst_n, o_rst_pin_oe}, 2'b01);
		@(posedge i_core_clk);
		i_vdd_ok <= 1'b1;
		wait_start;
		chk(n_wait < 8, 1'b1);
		rd(`RSS_ADDR_CAUSE);
		chk(rd_val, 8'h02);
		rd(`RSS_ADDR_IRQ_STAT);
		chk(rd_val, 8'h01);
		$display("supply monitor test done");
	endtask
	task t_flash(input logic exp);
		@(posedge i_core_clk);
		i_flash_wr_req <= 1'b1;
		i_flash_er_req <= 1'b1;
		@(posedge i_core_clk);
		#1;
		chk({o_flash_wr_go, o_flash_er_go}, {exp, exp});
		@(posedge i_core_clk);
		i_flash_wr_req <= 1'b0;
		i_flash_er_req <= 1'b0;
	endtask
	task t_flash_gate;
		t_flash(1'b1);
		wr(`RSS_ADDR_VMON, 8'h00);
		wr(`RSS_ADDR_CAUSE, 8'h00);
		t_flash(1'b0);
		rd(`RSS_ADDR_IRQ_STAT);
		chk(rd_val, 8'h04);
		wr(`RSS_ADDR_CAUSE, 8'h10);
		wait_start;
		rd(`RSS_ADDR_VMON);
		chk(rd_val, 8'h00);
		@(posedge i_core_clk);
		i_vdd_ok <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		#1;
		chk(o_core_rst_n, 1'b1);
		@(posedge i_core_clk);
		i_vdd_ok <= 1'b1;
		wr(`RSS_ADDR_VMON, 8'h01);
		wr(`RSS_ADDR_CAUSE, 8'h02);
		t_flash(1'b1);
		$display("flash gating test done");
	endtask

	// ==========
	// Verdict
	task conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		t_power_on;
		t_soft;
		t_wdt_ferr;
		t_pin;
		t_vmon;
		t_flash_gate;
		conclude;
	end

	// Hang guard, well past the expected run
	initial begin
		#100000;
		error_cnt++;
		conclude;
	end
endmodule
